/* rtl/icdp_consts.svh */
// Offsets, field positions, reset values and timing counts of the port
// Contract
// - No address pins; index cycle precedes data.
// - Command-select classifies each transfer cycle.
// - Buffer reached only via pointer bytes C0-C2.
// - Command C3 arms buffer data transfers.
// - Pointer increments after every buffer access.
// - C3 takes no data; next cycle moves data.
// - C0 low, C1 middle, C2 high byte; code keeps only C2 bit 0 (pointer bit 16).
// - Register write: command then data write.
// - Register read: command then driven data read.
// - Host always writes three pointers then start.
// - Buffer read mirrors write sequence.
// - Host samples read data during strobe.
// - Host holds chip select through access.
// - Read/write select high reads, low writes.
// - Low-lane enable strobes lower byte.
// - Bus clock divided 1-4 by straps.
`ifndef ICDP_CONSTS_SVH
`define ICDP_CONSTS_SVH
`define ICDP_IDX_PTR_LO 8'hc0
`define ICDP_IDX_PTR_MID 8'hc1
`define ICDP_IDX_PTR_HI 8'hc2
`define ICDP_IDX_START 8'hc3
`define ICDP_PTR_W 17
`define ICDP_MEM_BYTES 81920
`define ICDP_PTR_RST 17'h0_0000
`define ICDP_IDX_RST 8'h00
`define ICDP_PIN_RST 12'hfff
`define ICDP_HOST_SETUP_CYC 4
`define ICDP_HOST_STROBE_CYC 24
`define ICDP_HOST_HOLD_CYC 12
`endif

/* rtl/icdp_pkg.sv */
// Types shared by both ends of the indirect command/data port
`default_nettype none
package icdp_pkg;
  typedef enum logic [1:0] {
    ICDP_CMD_WRITE = 2'b00,
    ICDP_DATA_WRITE = 2'b01,
    ICDP_DATA_READ = 2'b10
  } icdp_op_e;
  typedef enum logic {
    ICDP_DEV_IDLE = 1'b0,
    ICDP_DEV_STROBE = 1'b1
  } icdp_dev_st_e;
  typedef enum logic [1:0] {
    ICDP_HST_IDLE = 2'b00,
    ICDP_HST_SETUP = 2'b01,
    ICDP_HST_STROBE = 2'b10,
    ICDP_HST_HOLD = 2'b11
  } icdp_hst_st_e;
endpackage
`default_nettype wire

/* rtl/icdp_if.sv */
// Pin bundle between controller and device, with the shared data wire
`timescale 1ns/10ps
`default_nettype none
interface icdp_if;
  logic cs_n;
  logic command_data_select;
  logic read_not_write;
  logic low_lane_enable_n;
  logic [7:0] host_data_out;
  logic host_data_oe;
  logic [7:0] dev_data_out;
  logic dev_data_oe;
  logic [7:0] data;
  // Undriven wire reads as pulled high
  assign data = dev_data_oe ? dev_data_out :
                host_data_oe ? host_data_out : 8'hff;
  modport dev (
    input cs_n, command_data_select, read_not_write, low_lane_enable_n,
    input data,
    output dev_data_out, dev_data_oe
  );
  modport host (
    output cs_n, command_data_select, read_not_write, low_lane_enable_n,
    output host_data_out, host_data_oe,
    input data
  );
endinterface
`default_nettype wire

/* rtl/icdp_device.sv */
// Device end: indexed registers and pointer-addressed display buffer
`timescale 1ns/10ps
`default_nettype none
`include "icdp_consts.svh"
module icdp_device
  import icdp_pkg::*;
#(
  parameter int MEM_BYTES = `ICDP_MEM_BYTES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host pins
  icdp_if.dev bus,
  // Straps and status
  input wire logic [1:0] div_strap,
  output logic mem_armed
);

  localparam int PW = `ICDP_PTR_W;

  if (MEM_BYTES < 1 || MEM_BYTES > (1 << PW)) begin : g_chk
    $error("MEM_BYTES does not fit the pointer");
  end

  function automatic logic [7:0] reg_read(
    input logic [7:0] idx,
    input logic [PW-1:0] ptr
  );
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      `ICDP_IDX_PTR_LO: r = ptr[7:0];
      `ICDP_IDX_PTR_MID: r = ptr[15:8];
      `ICDP_IDX_PTR_HI: r = {7'h00, ptr[16]};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  function automatic logic in_mem(input logic [PW-1:0] ptr);
    return ({15'h0000, ptr} < 32'(MEM_BYTES));
  endfunction

  // Bus clock enable from the strap-selected divider
  logic [1:0] div_sel_ff;
  logic [1:0] div_cnt_ff;
  logic bus_en;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_sel_ff <= div_strap;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt_ff <= 2'h0;
    end else if (div_cnt_ff == div_sel_ff) begin
      div_cnt_ff <= 2'h0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 2'h1;
    end
  end

  assign bus_en = (div_cnt_ff == div_sel_ff);

  // Three-stage pin capture; a bit counts once stages two and three agree
  logic [11:0] pins;
  logic [11:0] s1_ff;
  logic [11:0] s2_ff;
  logic [11:0] s3_ff;
  logic [11:0] agreed_ff;

  assign pins = {bus.cs_n, bus.command_data_select, bus.read_not_write,
                 bus.low_lane_enable_n, bus.data};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= `ICDP_PIN_RST;
      s2_ff <= `ICDP_PIN_RST;
      s3_ff <= `ICDP_PIN_RST;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      agreed_ff <= `ICDP_PIN_RST;
    end else if (bus_en) begin
      agreed_ff <= (s2_ff & s3_ff) | (agreed_ff & (s2_ff ^ s3_ff));
    end
  end

  logic a_cs_n;
  logic a_cds;
  logic a_rnw;
  logic a_str_n;
  logic [7:0] a_data;
  logic strobe_on;

  assign a_cs_n = agreed_ff[11];
  assign a_cds = agreed_ff[10];
  assign a_rnw = agreed_ff[9];
  assign a_str_n = agreed_ff[8];
  assign a_data = agreed_ff[7:0];
  assign strobe_on = !a_cs_n && !a_str_n;

  // Cycle sequencing
  icdp_dev_st_e state_ff;
  logic start_ev;
  logic end_ev;
  logic cyc_cds_ff;
  logic cyc_rnw_ff;

  assign start_ev = bus_en && (state_ff == ICDP_DEV_IDLE) && strobe_on;
  assign end_ev = bus_en && (state_ff == ICDP_DEV_STROBE) && !strobe_on;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ICDP_DEV_IDLE;
    end else begin
      case (state_ff)
        ICDP_DEV_IDLE: begin
          if (start_ev) begin
            state_ff <= ICDP_DEV_STROBE;
          end
        end
        ICDP_DEV_STROBE: begin
          if (end_ev) begin
            state_ff <= ICDP_DEV_IDLE;
          end
        end
        default: state_ff <= ICDP_DEV_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cyc_cds_ff <= 1'b1;
      cyc_rnw_ff <= 1'b1;
    end else if (start_ev) begin
      cyc_cds_ff <= a_cds;
      cyc_rnw_ff <= a_rnw;
    end
  end

  logic cmd_end;
  logic wr_end;
  logic rd_end;

  assign cmd_end = end_ev && !cyc_cds_ff;
  assign wr_end = end_ev && cyc_cds_ff && !cyc_rnw_ff;
  assign rd_end = end_ev && cyc_cds_ff && cyc_rnw_ff;

  // Register index, latched when the command strobe ends
  logic [7:0] idx_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idx_ff <= `ICDP_IDX_RST;
    end else if (cmd_end) begin
      idx_ff <= a_data;
    end
  end

  // Buffer mode: set by the start index, left by any other command
  logic armed_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed_ff <= 1'b0;
    end else if (cmd_end) begin
      armed_ff <= (a_data == `ICDP_IDX_START);
    end
  end

  assign mem_armed = armed_ff;

  // Memory pointer
  logic [PW-1:0] ptr_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_ff <= `ICDP_PTR_RST;
    end else if (armed_ff && (wr_end || rd_end)) begin
      ptr_ff <= ptr_ff + 17'h0_0001;
    end else if (wr_end) begin
      case (idx_ff)
        `ICDP_IDX_PTR_LO: ptr_ff[7:0] <= a_data;
        `ICDP_IDX_PTR_MID: ptr_ff[15:8] <= a_data;
        `ICDP_IDX_PTR_HI: ptr_ff[16] <= a_data[0];
        default: ptr_ff <= ptr_ff;
      endcase
    end
  end

  // Display buffer
  logic [7:0] mem_ff [MEM_BYTES];

  always_ff @(posedge clk) begin
    if (armed_ff && wr_end && in_mem(ptr_ff)) begin
      mem_ff[ptr_ff] <= a_data;
    end
  end

  // Read data latched and driven from the sampled strobe start to the sampled strobe end
  logic [7:0] dout_ff;
  logic doe_ff;
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (armed_ff) begin
      if (in_mem(ptr_ff)) begin
        rd_byte = mem_ff[ptr_ff];
      end
    end else begin
      rd_byte = reg_read(idx_ff, ptr_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout_ff <= 8'h00;
      doe_ff <= 1'b0;
    end else if (start_ev && a_cds && a_rnw) begin
      dout_ff <= rd_byte;
      doe_ff <= 1'b1;
    end else if (end_ev) begin
      doe_ff <= 1'b0;
    end
  end

  assign bus.dev_data_out = dout_ff;
  assign bus.dev_data_oe = doe_ff;

endmodule
`default_nettype wire

/* rtl/icdp_host.sv */
// Controller end: runs command, data write and data read cycles
`timescale 1ns/10ps
`default_nettype none
`include "icdp_consts.svh"
module icdp_host
  import icdp_pkg::*;
#(
  parameter int SETUP_CYC = `ICDP_HOST_SETUP_CYC,
  parameter int STROBE_CYC = `ICDP_HOST_STROBE_CYC,
  parameter int HOLD_CYC = `ICDP_HOST_HOLD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Device pins
  icdp_if.host bus,
  // Request
  input wire logic req_valid,
  input wire icdp_op_e req_op,
  input wire logic [7:0] req_data,
  output logic req_ready,
  // Answer
  output logic done,
  output logic [7:0] rsp_data
);

  if (SETUP_CYC < 1 || SETUP_CYC > 255 || STROBE_CYC < 16 ||
      STROBE_CYC > 255 || HOLD_CYC < 12 || HOLD_CYC > 255) begin : g_chk
    $error("Host cycle counts out of range");
  end

  function automatic logic [7:0] cnt_of(input int n);
    return 8'(n - 1);
  endfunction

  // Read data capture, three stages with agreement
  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  logic [7:0] s3_ff;
  logic [7:0] rd_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= 8'hff;
      s2_ff <= 8'hff;
      s3_ff <= 8'hff;
      rd_ff <= 8'hff;
    end else begin
      s1_ff <= bus.data;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      rd_ff <= (s2_ff & s3_ff) | (rd_ff & (s2_ff ^ s3_ff));
    end
  end

  icdp_hst_st_e state_ff;
  logic [7:0] cnt_ff;
  logic is_read_ff;
  logic cs_n_ff;
  logic cds_ff;
  logic rnw_ff;
  logic str_n_ff;
  logic [7:0] hdo_ff;
  logic hoe_ff;
  logic ready_ff;
  logic done_ff;
  logic [7:0] rsp_ff;
  logic take;

  assign take = (state_ff == ICDP_HST_IDLE) && ready_ff && req_valid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ICDP_HST_IDLE;
      cnt_ff <= 8'h00;
      is_read_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      cds_ff <= 1'b1;
      rnw_ff <= 1'b1;
      str_n_ff <= 1'b1;
      hdo_ff <= 8'h00;
      hoe_ff <= 1'b0;
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        ICDP_HST_IDLE: begin
          ready_ff <= !take;
          if (take) begin
            is_read_ff <= (req_op == ICDP_DATA_READ);
            cs_n_ff <= 1'b0;
            cds_ff <= (req_op != ICDP_CMD_WRITE);
            rnw_ff <= (req_op == ICDP_DATA_READ);
            hdo_ff <= req_data;
            hoe_ff <= (req_op != ICDP_DATA_READ);
            cnt_ff <= cnt_of(SETUP_CYC);
            state_ff <= ICDP_HST_SETUP;
          end
        end
        ICDP_HST_SETUP: begin
          if (cnt_ff == 8'h00) begin
            str_n_ff <= 1'b0;
            cnt_ff <= cnt_of(STROBE_CYC);
            state_ff <= ICDP_HST_STROBE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        ICDP_HST_STROBE: begin
          if (cnt_ff == 8'h00) begin
            str_n_ff <= 1'b1;
            cnt_ff <= cnt_of(HOLD_CYC);
            state_ff <= ICDP_HST_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        ICDP_HST_HOLD: begin
          if (cnt_ff == 8'h00) begin
            cs_n_ff <= 1'b1;
            cds_ff <= 1'b1;
            rnw_ff <= 1'b1;
            hoe_ff <= 1'b0;
            done_ff <= 1'b1;
            ready_ff <= 1'b1;
            state_ff <= ICDP_HST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: state_ff <= ICDP_HST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_ff <= 8'h00;
    end else if (state_ff == ICDP_HST_STROBE && cnt_ff == 8'h00 &&
                 is_read_ff) begin
      rsp_ff <= rd_ff;
    end
  end

  assign bus.cs_n = cs_n_ff;
  assign bus.command_data_select = cds_ff;
  assign bus.read_not_write = rnw_ff;
  assign bus.low_lane_enable_n = str_n_ff;
  assign bus.host_data_out = hdo_ff;
  assign bus.host_data_oe = hoe_ff;
  assign req_ready = ready_ff;
  assign done = done_ff;
  assign rsp_data = rsp_ff;

endmodule
`default_nettype wire

/* tb/icdp_asserts.sv */
// Pin-level checks on the bundle joining host and device
`timescale 1ns/10ps
`default_nettype none
module icdp_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control pins
  input wire logic cs_n,
  input wire logic command_data_select,
  input wire logic read_not_write,
  input wire logic low_lane_enable_n,
  // Data drivers
  input wire logic host_data_oe,
  input wire logic dev_data_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_no_contention: assert property (
    !(host_data_oe && dev_data_oe))
    else $error("both ends drive data");
  chk_dev_read_only: assert property (
    dev_data_oe |-> !cs_n && read_not_write && command_data_select)
    else $error("device drives outside a data read");
  chk_host_drive_write: assert property (
    host_data_oe |-> !cs_n && !read_not_write)
    else $error("host drives outside a write");
  chk_strobe_in_cs: assert property (
    !low_lane_enable_n |-> !cs_n && $past(!cs_n))
    else $error("strobe without chip select");
  chk_cs_held: assert property (
    $fell(cs_n) |=> !cs_n [*8])
    else $error("chip select released early");
  chk_strobe_width: assert property (
    $fell(low_lane_enable_n) |=> !low_lane_enable_n [*8])
    else $error("strobe too short");
  chk_read_answer: assert property (
    $fell(low_lane_enable_n) && read_not_write |-> ##[3:12] dev_data_oe)
    else $error("read not answered");
  chk_select_stable: assert property (
    !cs_n && $past(!cs_n) |-> $stable(command_data_select) &&
      $stable(read_not_write))
    else $error("cycle kind changed in access");
  chk_dev_release: assert property (
    $rose(low_lane_enable_n) |-> ##[0:11] !dev_data_oe)
    else $error("device holds data after strobe");
endmodule
`default_nettype wire

/* tb/indirect_command_data_port_tb.sv */
// Testbench joining host and device ends through the pin bundle
`timescale 1ns/10ps
`default_nettype none
module indirect_command_data_port_tb import icdp_pkg::*;;
  logic clk;
  logic rst_n;
  logic req_valid;
  icdp_op_e req_op;
  logic [7:0] req_data;
  logic req_ready;
  logic done;
  logic [7:0] rsp_data;
  logic [1:0] div_strap;
  logic mem_armed;
  int miscompares = 0;
  int n_checks = 0;
  // Read answer delay: clocks from strobe low to device drive
  int lat = 0;
  int rd_lat = 0;
  logic oe_seen = 1'b0;

  icdp_if bus_if ();
  icdp_device icdp_device_i (.clk(clk), .rst_n(rst_n), .bus(bus_if),
    .div_strap(div_strap), .mem_armed(mem_armed));
  icdp_host icdp_host_i (.clk(clk), .rst_n(rst_n), .bus(bus_if),
    .req_valid(req_valid), .req_op(req_op), .req_data(req_data),
    .req_ready(req_ready), .done(done), .rsp_data(rsp_data));
  icdp_asserts icdp_asserts_i (.clk(clk), .rst_n(rst_n),
    .cs_n(bus_if.cs_n), .command_data_select(bus_if.command_data_select),
    .read_not_write(bus_if.read_not_write),
    .low_lane_enable_n(bus_if.low_lane_enable_n),
    .host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (bus_if.low_lane_enable_n) begin
      lat <= 0;
    end else begin
      lat <= lat + 1;
    end
    if (!bus_if.low_lane_enable_n && bus_if.dev_data_oe && !oe_seen) begin
      rd_lat <= lat;
    end
    oe_seen <= bus_if.dev_data_oe;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One host request, held until taken, then wait for its answer
  task automatic op(input icdp_op_e o, input logic [7:0] d);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= o;
    req_data <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 200);
    if (n >= 200) begin
      miscompares++;
      $display("BAD t=%0t no answer", $time);
      stop_test();
    end
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    op(ICDP_CMD_WRITE, idx);
    op(ICDP_DATA_WRITE, d);
  endtask

  task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
    op(ICDP_CMD_WRITE, idx);
    op(ICDP_DATA_READ, 8'h00);
    check(rsp_data, exp);
  endtask

  task automatic set_ptr(input logic [16:0] a);
    wr_reg(8'hc0, a[7:0]);
    wr_reg(8'hc1, a[15:8]);
    wr_reg(8'hc2, {7'h00, a[16]});
    op(ICDP_CMD_WRITE, 8'hc3);
  endtask

  task automatic rd_mem(input logic [7:0] exp);
    op(ICDP_DATA_READ, 8'h00);
    check(rsp_data, exp);
  endtask

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = ICDP_CMD_WRITE;
    req_data = 8'h00;
    div_strap = 2'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wr_reg(8'hc0, 8'h34);
    wr_reg(8'hc1, 8'h12);
    wr_reg(8'hc2, 8'hff);
    rd_reg(8'hc0, 8'h34);
    rd_reg(8'hc1, 8'h12);
    rd_reg(8'hc2, 8'h01);
    rd_reg(8'h26, 8'h00);
    $display("test pointer_regs done");
    set_ptr(17'h0_0200);
    check({7'h00, mem_armed}, 8'h01);
    op(ICDP_DATA_WRITE, 8'haa);
    op(ICDP_DATA_WRITE, 8'h55);
    rd_reg(8'hc0, 8'h02);
    check({7'h00, mem_armed}, 8'h00);
    set_ptr(17'h0_0200);
    rd_mem(8'haa);
    rd_mem(8'h55);
    $display("test buffer_pair done");
    // Last byte of the buffer, then one past the end
    set_ptr(17'h1_3fff);
    op(ICDP_DATA_WRITE, 8'h5a);
    op(ICDP_DATA_WRITE, 8'h66);
    set_ptr(17'h1_3fff);
    rd_mem(8'h5a);
    rd_mem(8'h00);
    rd_reg(8'hc0, 8'h01);
    rd_reg(8'hc2, 8'h01);
    $display("test buffer_end done");
    // Every divide ratio, reset in mid-run
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      rst_n <= 1'b0;
      div_strap <= 2'(s);
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(8'hc1, 8'h00);
      set_ptr(17'h0_0201);
      rd_mem(8'h55);
      check({7'h00, (rd_lat >= 5 + s && rd_lat <= 5 + 2 * s)}, 8'h01);
      op(ICDP_DATA_WRITE, 8'h3c);
      set_ptr(17'h0_0202);
      rd_mem(8'h3c);
    end
    $display("test divide_ratios done");
    stop_test();
  end
endmodule
`default_nettype wire
